//--- hw/fip_event_fifo.v
/*
 * small in-order event queue for pending interrupt events.
 * assumes one clock, asynchronous active-high reset, writer honours full.
 */
`timescale 1ns/1ps
module fip_event_fifo #(
   parameter W  = 16,
   parameter AW = 3
)(
   // clock and reset
   input  wire          sys_clk,
   input  wire          reset,
   // write side
   input  wire          wr_en,
   input  wire [W-1:0]  wr_data,
   output wire          full,
   // read side
   input  wire          rd_en,
   output wire [W-1:0]  rd_data,
   output wire          empty
);
   reg [W-1:0]  mem [0:(1<<AW)-1];
   reg [AW:0]   wp_ff;
   reg [AW:0]   rp_ff;

   assign empty   = (wp_ff == rp_ff);
   assign full    = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
   assign rd_data = mem[rp_ff[AW-1:0]];

   // events leave in arrival order
   always @(posedge sys_clk)
   begin
      if (wr_en && !full)
         mem[wp_ff[AW-1:0]] <= wr_data;
   end

   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         wp_ff <= {(AW+1){1'b0}};
         rp_ff <= {(AW+1){1'b0}};
      end
      else
      begin
         if (wr_en && !full)
            wp_ff <= wp_ff + 1'b1;
         if (rd_en && !empty)
            rp_ff <= rp_ff + 1'b1;
      end
   end
endmodule // fip_event_fifo

//--- hw/fip_irq_proxy.v
/*
 * interrupt proxy: turns lower-segment slave events into interrupt
 * sections of the upper diagnostic frame, one at a time.
 * assumes event strobes and slave frame bytes come from logic on sys_clk;
 * the frame builder reads section bytes by index and acknowledges.
 */
`timescale 1ns/1ps
`include "fip_regs.vh"
module fip_irq_proxy #(
   parameter QAW       = 3,
   parameter STARTUP_CYC = 32'd100000
)(
   // clock and reset
   input  wire        sys_clk,
   input  wire        reset,
   // mode
   input  wire        redundant_mode,
   // slave event strobes, one cycle each
   input  wire        ev_diag,
   input  wire        ev_fail,
   input  wire        ev_restore,
   input  wire        ev_slave_irq,
   input  wire        slave_irq_capable,
   input  wire        slave_dpv1_mode,
   input  wire [6:0]  ev_addr,
   input  wire [7:0]  ev_irq_type,
   // slave frame bytes following an accepted diag or routed event
   input  wire        sf_valid,
   input  wire [7:0]  sf_data,
   input  wire        sf_last,
   // section read side
   input  wire [5:0]  rd_idx,
   input  wire        sec_ack,
   // outputs
   output reg         ev_ready,
   output reg         sec_present,
   output reg  [7:0]  sec_base,
   output reg  [5:0]  sec_len,
   output reg  [7:0]  rd_byte,
   output reg         startup_done
);
   localparam ST_IDLE = 2'h0;
   localparam ST_LOAD = 2'h1;
   localparam ST_SHOW = 2'h2;

   reg [1:0]   state_ff;
   reg [7:0]   buf_ff [0:62];
   reg [5:0]   wcnt_ff;
   reg         ovf_ff;
   reg [7:0]   seq_ff;
   reg [31:0]  su_cnt_ff;
   reg [127:0] ins_pend_ff;
   reg [6:0]   ins_scan_ff;
   wire [15:0] q_rd;
   wire        q_empty;
   wire        q_full;
   reg         q_wr;
   reg  [15:0] q_wdata;
   reg         q_rd_en;
   wire [1:0]  cur_kind = q_rd[15:14];
   wire [6:0]  cur_addr = q_rd[13:7];
   wire        diag_ok  = ev_diag && !(slave_irq_capable && slave_dpv1_mode);

   fip_event_fifo #(.W(16), .AW(QAW)) u_q (
      .sys_clk (sys_clk),
      .reset   (reset),
      .wr_en   (q_wr),
      .wr_data (q_wdata),
      .full    (q_full),
      .rd_en   (q_rd_en),
      .rd_data (q_rd),
      .empty   (q_empty)
   );

   ////////////////////////////////////////////////////////////////////////
   // event intake; one event per cycle, priority diag, route, fail, restore
   always @*
   begin
      q_wr    = 1'b0;
      q_wdata = 16'h0000;
      if (!q_full)
      begin
         if (diag_ok)
         begin
            q_wr    = 1'b1;
            q_wdata = {`FIP_EV_DIAG, ev_addr, 7'h00};
         end
         else if (ev_slave_irq && slave_irq_capable)
         begin
            q_wr    = 1'b1;
            q_wdata = {`FIP_EV_ROUTE, ev_addr, ev_irq_type[6:0]};
         end
         else if (ev_fail && startup_done)
         begin
            q_wr    = 1'b1;
            q_wdata = {`FIP_EV_REMOVE, ev_addr, 7'h00};
         end
         else if (ev_restore && startup_done)
         begin
            q_wr    = 1'b1;
            q_wdata = {`FIP_EV_INSERT, ev_addr, 7'h00};
         end
         else if (startup_done && ins_pend_ff[ins_scan_ff])
         begin
            q_wr    = 1'b1;
            q_wdata = {`FIP_EV_INSERT, ins_scan_ff, 7'h00};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // start-up delay and retained insertions
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         su_cnt_ff    <= 32'h00000000;
         startup_done <= 1'b0;
         ins_pend_ff  <= 128'h0;
         ins_scan_ff  <= 7'h00;
      end
      else
      begin
         if (!startup_done)
         begin
            su_cnt_ff <= su_cnt_ff + 32'h00000001;
            if (su_cnt_ff >= STARTUP_CYC - 32'h00000001)
               startup_done <= 1'b1;
         end
         // insertion seen during start-up is kept; a failure later in start-up cancels it
         if (!startup_done && ev_restore)
            ins_pend_ff[ev_addr] <= 1'b1;
         else if (!startup_done && ev_fail)
            ins_pend_ff[ev_addr] <= 1'b0;
         if (startup_done)
         begin
            if (q_wr && !diag_ok && !(ev_slave_irq && slave_irq_capable) && !ev_fail && !ev_restore)
               ins_pend_ff[ins_scan_ff] <= 1'b0;
            if (!ins_pend_ff[ins_scan_ff] || q_wr)
               ins_scan_ff <= ins_scan_ff + 7'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // section build and presentation
   // limitation: slave frame bytes are taken only in ST_LOAD; source waits for ev_ready
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         state_ff    <= ST_IDLE;
         wcnt_ff     <= 6'h00;
         ovf_ff      <= 1'b0;
         seq_ff      <= 8'h00;
         q_rd_en     <= 1'b0;
         ev_ready    <= 1'b0;
         sec_present <= 1'b0;
         sec_base    <= `FIP_SEC_BASE_STD;
         sec_len     <= 6'h00;
         rd_byte     <= 8'h00;
      end
      else
      begin
         q_rd_en  <= 1'b0;
         sec_base <= redundant_mode ? `FIP_SEC_BASE_RED : `FIP_SEC_BASE_STD;
         rd_byte  <= (rd_idx < sec_len) ? buf_ff[rd_idx] : 8'h00;
         case (state_ff)
            ST_IDLE:
            begin
               sec_present <= 1'b0;
               if (!q_empty && !q_rd_en)
               begin
                  buf_ff[0] <= {1'b0, cur_addr}; // address byte for every kind; type byte set below per kind
                  buf_ff[2] <= `FIP_SLOT_WHOLE;
                  buf_ff[3] <= {seq_ff[4:0], 3'h0};
                  seq_ff    <= seq_ff + 8'h01;
                  wcnt_ff   <= 6'h00;
                  ovf_ff    <= 1'b0;
                  case (cur_kind)
                     `FIP_EV_DIAG:
                     begin
                        buf_ff[1] <= `FIP_TYPE_DIAG;
                        state_ff  <= ST_LOAD;
                     end
                     `FIP_EV_ROUTE:
                     begin
                        buf_ff[1] <= {1'b0, q_rd[6:0]};
                        state_ff  <= ST_LOAD;
                     end
                     `FIP_EV_REMOVE:
                     begin
                        buf_ff[1] <= `FIP_TYPE_REMOVE;
                        sec_len   <= `FIP_HDR_LEN + `FIP_LEN_REMINS;
                        state_ff  <= ST_SHOW;
                     end
                     default:
                     begin
                        buf_ff[1] <= `FIP_TYPE_INSERT;
                        sec_len   <= `FIP_HDR_LEN + `FIP_LEN_REMINS;
                        state_ff  <= ST_SHOW;
                     end
                  endcase
               end
            end
            ST_LOAD:
            begin
               if (sf_valid)
               begin
                  if (wcnt_ff < `FIP_ADD_MAX)
                  begin
                     buf_ff[`FIP_HDR_LEN + wcnt_ff] <= sf_data;
                     wcnt_ff <= wcnt_ff + 6'h01;
                  end
                  else
                     ovf_ff <= 1'b1;
                  if (sf_last)
                  begin
                     if (wcnt_ff >= `FIP_ADD_MAX && !sf_last)
                        ovf_ff <= 1'b1;
                     state_ff <= ST_SHOW;
                     sec_len  <= `FIP_HDR_LEN + ((wcnt_ff < `FIP_ADD_MAX) ? wcnt_ff + 6'h01 : wcnt_ff);
                  end
               end
            end
            ST_SHOW:
            begin
               // overflow flag applied once the frame is complete
               if (ovf_ff && cur_kind == `FIP_EV_DIAG)
               begin
                  buf_ff[`FIP_HDR_LEN + `FIP_OVF_IDX][`FIP_OVF_BIT] <= 1'b1;
                  ovf_ff <= 1'b0;
               end
               sec_present <= 1'b1;
               if (sec_ack && sec_present)
               begin
                  sec_present <= 1'b0;
                  q_rd_en     <= 1'b1;
                  state_ff    <= ST_IDLE;
               end
            end
            default:
               state_ff <= ST_IDLE;
         endcase
         // ready follows the next state so no byte is offered after the frame closes
         if (state_ff == ST_IDLE)
            ev_ready <= !q_empty && !q_rd_en && (cur_kind == `FIP_EV_DIAG || cur_kind == `FIP_EV_ROUTE);
         else if (state_ff == ST_LOAD)
            ev_ready <= !(sf_valid && sf_last);
         else
            ev_ready <= 1'b0;
      end
   end
endmodule // fip_irq_proxy

//--- hw/fip_regs.vh
/*
 * constants for the fieldbus interrupt proxy: frame offsets, interrupt
 * type codes, header layout and event kind codes.
 * assumes it is included by bare name from hw/ design files.
 */
// What this block does
// - a diagnosis from a basic slave or a slave that cannot raise interrupts raises a proxy diagnostic interrupt.
// - the slave diagnostic frame is copied into the additional information and bytes beyond 59 are dropped.
// - on truncation bit 7 of the third forwarded byte (byte x+6) is set as the overflow flag.
// - a diagnosis from an interrupt-capable slave running in DPV1 mode raises no proxy interrupt.
// - a failing slave raises a removal interrupt and a restored slave an insertion interrupt.
// - the interrupt section starts at byte 168 in redundant operation and at byte 160 otherwise.
// - for a modular slave the removal or insertion information describes the whole slave.
// - removal and insertion are held back until start-up delay ends, insertions during it are kept.
// - an interrupt raised by an interrupt-capable slave is forwarded upward.
// - a routed interrupt is passed unchanged except slot and sequence numbers and bit 7 of its type byte, which is cleared.
// - the header is 4 bytes and the additional information at most 59 bytes.
// - the interrupt section is part of the diagnostic frame only while an interrupt is present.
`ifndef FIP_REGS_VH
`define FIP_REGS_VH
`define FIP_SEC_BASE_RED   8'ha8
`define FIP_SEC_BASE_STD   8'ha0
`define FIP_HDR_LEN        6'h04
`define FIP_ADD_MAX        6'h3b
`define FIP_OVF_IDX        6'h02
`define FIP_OVF_BIT        7
`define FIP_TYPE_DIAG      8'h01
`define FIP_TYPE_REMOVE    8'h03
`define FIP_TYPE_INSERT    8'h04
`define FIP_SLOT_WHOLE     8'h00
`define FIP_LEN_REMINS     6'h00
`define FIP_EV_DIAG        2'h0
`define FIP_EV_REMOVE      2'h1
`define FIP_EV_INSERT      2'h2
`define FIP_EV_ROUTE       2'h3
`endif

//--- tb/fip_irq_proxy_bench.sv
/* bench for the interrupt proxy, scenario tasks over the segment model.
   assumes start-up delay shortened to 20 cycles. */
`timescale 1ns/1ps
module fip_irq_proxy_bench;
   reg        sys_clk, reset, redundant_mode;
   wire       ev_diag, ev_fail, ev_restore, ev_slave_irq, slave_irq_capable, slave_dpv1_mode;
   wire       sf_valid, sf_last, sec_ack, ev_ready, sec_present, startup_done;
   wire [6:0] ev_addr;
   wire [7:0] ev_irq_type, sf_data, sec_base, rd_byte;
   wire [5:0] rd_idx, sec_len;
   integer    n_errors, compares;
   fip_irq_proxy #(.STARTUP_CYC(32'd20)) dut_u (.*);
   fip_seg_model seg_u (.*);
   ////////////////////////////////////////////////////////////////
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp)
         begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   task rdc(input [5:0] idx, input [7:0] exp);
      reg [7:0] b;
      begin
         seg_u.rd(idx, b);
         chk(b, exp);
      end
   endtask
   // returns whether a section showed within n cycles
   task look(input integer n, output reg seen);
      integer i;
      begin
         seen = 1'b0;
         for (i = 0; i < n && !seen; i = i + 1)
         begin
            @(negedge sys_clk);
            seen = (sec_present === 1'b1);
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////
   task t_startup;
      reg s;
      begin
         seg_u.ev(4'h2, 7'h0a, 1'b0, 1'b0, 8'h00);
         seg_u.ev(4'h4, 7'h0a, 1'b0, 1'b0, 8'h00);
         @(negedge sys_clk);
         chk({7'h0, sec_present}, 8'h00);
         chk({7'h0, startup_done}, 8'h00);
         look(40, s);
         chk({7'h0, s}, 8'h01);
         chk({7'h0, startup_done}, 8'h01);
         rdc(6'h00, 8'h0a);
         rdc(6'h01, 8'h04);
         rdc(6'h02, 8'h00);
         chk({2'b00, sec_len}, 8'h04);
         chk(sec_base, 8'ha0);
         seg_u.ack;
         look(12, s);
         chk({7'h0, s}, 8'h00);
      end
   endtask
   task t_diag;
      reg s;
      begin
         @(posedge sys_clk) redundant_mode <= 1'b1;
         seg_u.ev(4'h1, 7'h05, 1'b0, 1'b0, 8'h00);
         seg_u.frame(59);
         look(20, s);
         chk({7'h0, s}, 8'h01);
         chk({7'h0, ev_ready}, 8'h00);
         chk({2'b00, sec_len}, 8'h3f);
         chk(sec_base, 8'ha8);
         rdc(6'h01, 8'h01);
         rdc(6'h06, 8'h02);
         seg_u.ack;
         seg_u.ev(4'h1, 7'h05, 1'b0, 1'b0, 8'h00);
         seg_u.frame(64);
         look(20, s);
         chk({2'b00, sec_len}, 8'h3f);
         rdc(6'h06, 8'h82);
         rdc(6'h3e, 8'h3a);
         seg_u.ack;
         @(posedge sys_clk) redundant_mode <= 1'b0;
      end
   endtask
   task t_dpv1;
      reg s;
      begin
         seg_u.ev(4'h1, 7'h07, 1'b1, 1'b1, 8'h00);
         look(15, s);
         chk({7'h0, s}, 8'h00);
         chk({7'h0, ev_ready}, 8'h00);
         seg_u.ev(4'h1, 7'h07, 1'b1, 1'b0, 8'h00);
         seg_u.frame(3);
         look(20, s);
         chk({7'h0, s}, 8'h01);
         rdc(6'h05, 8'h01);
         seg_u.ack;
         seg_u.ev(4'h8, 7'h09, 1'b1, 1'b1, 8'h02);
         seg_u.frame(3);
         look(20, s);
         chk({7'h0, s}, 8'h01);
         rdc(6'h01, 8'h02);
         rdc(6'h02, 8'h00);
         rdc(6'h06, 8'h02);
         chk({2'b00, sec_len}, 8'h07);
         seg_u.ack;
      end
   endtask
   task t_queue;
      reg s;
      begin
         seg_u.ev(4'h2, 7'h0c, 1'b0, 1'b0, 8'h00);
         seg_u.ev(4'h4, 7'h0c, 1'b0, 1'b0, 8'h00);
         look(20, s);
         rdc(6'h01, 8'h03);
         seg_u.ack;
         look(20, s);
         chk({7'h0, s}, 8'h01);
         rdc(6'h01, 8'h04);
         seg_u.ack;
         look(12, s);
         chk({7'h0, s}, 8'h00);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   task results;
      begin
         if (n_errors == 0 && compares > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial
   begin
      {n_errors, compares} = 64'h0;
      {reset, redundant_mode} = 2'b10;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      t_startup;
      t_diag;
      t_dpv1;
      t_queue;
      results;
   end
   // the scenarios take a few hundred cycles; this cuts a hang short
   initial
   begin
      #50000;
      n_errors = n_errors + 1;
      results;
   end
endmodule // fip_irq_proxy_bench

//--- tb/fip_irq_proxy_sva.sv
/* port checks for the interrupt proxy.
   assumes bind by name into fip_irq_proxy, one clock. */
`timescale 1ns/1ps
module fip_irq_proxy_sva (
   // clock, reset, inputs
   input wire       sys_clk, reset, redundant_mode, ev_fail, sf_valid, sf_last, sec_ack,
   // outputs
   input wire       ev_ready, sec_present, startup_done,
   input wire [7:0] sec_base,
   input wire [5:0] sec_len
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_base_mode: assert property (sec_present |-> sec_base == ($past(redundant_mode) ? 8'ha8 : 8'ha0))
      else $error("section base wrong");
   a_len_floor: assert property (sec_present |-> sec_len >= 6'h04)
      else $error("section shorter than header");
   a_startup_kept: assert property (startup_done |=> startup_done)
      else $error("start-up flag dropped");
   a_section_stands: assert property (sec_present && !sec_ack |=> sec_present)
      else $error("section vanished before ack");
   a_ack_release: assert property (sec_present && sec_ack |-> ##[1:2] !sec_present)
      else $error("section kept after ack");
   a_len_stable: assert property (sec_present && !sec_ack |=> $stable(sec_len))
      else $error("length changed while shown");
   a_fail_answer: assert property (ev_fail && startup_done && !sec_present && !ev_ready |-> ##[2:4] sec_present)
      else $error("no removal section");
   a_diag_answer: assert property (sf_valid && sf_last && ev_ready && !sec_present |-> ##[1:3] sec_present)
      else $error("no section after frame");
   a_ready_close: assert property (sf_valid && sf_last && ev_ready |=> !ev_ready)
      else $error("ready kept after last byte");
   c_red: cover property ($rose(sec_present) && redundant_mode);
   c_full: cover property (sec_present && sec_len == 6'h3f);
   c_start: cover property ($rose(startup_done));
endmodule // fip_irq_proxy_sva
bind fip_irq_proxy fip_irq_proxy_sva chk_u (.*);

//--- tb/fip_seg_model.sv
/* lower-segment slaves and upper reader for the proxy.
   assumes the bench calls its tasks; drives follow rising edges. */
`timescale 1ns/1ps
module fip_seg_model (
   // seen from the design
   input  wire       sys_clk, ev_ready,
   input  wire [7:0] rd_byte,
   // slave side
   output reg        ev_diag, ev_fail, ev_restore, ev_slave_irq, slave_irq_capable, slave_dpv1_mode,
   output reg  [6:0] ev_addr,
   output reg  [7:0] ev_irq_type, sf_data,
   output reg        sf_valid, sf_last,
   // upper reader
   output reg  [5:0] rd_idx,
   output reg        sec_ack
);
   initial
   begin
      {ev_diag, ev_fail, ev_restore, ev_slave_irq, slave_irq_capable, slave_dpv1_mode} = 6'h00;
      {ev_addr, ev_irq_type, sf_data, sf_valid, sf_last, rd_idx, sec_ack} = 39'h0;
   end
   // kind is one-hot {irq, restore, fail, diag}
   task ev(input [3:0] kind, input [6:0] addr, input cap, input dpv1, input [7:0] typ);
      begin
         @(posedge sys_clk);
         {ev_slave_irq, ev_restore, ev_fail, ev_diag} <= kind;
         {ev_addr, slave_irq_capable, slave_dpv1_mode, ev_irq_type} <= {addr, cap, dpv1, typ};
         @(posedge sys_clk);
         {ev_slave_irq, ev_restore, ev_fail, ev_diag} <= 4'h0;
      end
   endtask
   // byte i of a frame carries i; released data is inverted so stale values never match
   task frame(input integer n);
      integer i;
      begin
         for (i = 0; i < 20 && ev_ready !== 1'b1; i = i + 1)
            @(negedge sys_clk);
         for (i = 0; i < n; i = i + 1)
         begin
            @(posedge sys_clk);
            {sf_valid, sf_data, sf_last} <= {1'b1, i[7:0], i == n - 1};
         end
         @(posedge sys_clk);
         {sf_valid, sf_last, sf_data} <= {2'b00, ~sf_data};
      end
   endtask
   task rd(input [5:0] idx, output [7:0] b);
      begin
         @(posedge sys_clk);
         rd_idx <= idx;
         @(posedge sys_clk);
         @(negedge sys_clk);
         b = rd_byte;
      end
   endtask
   task ack;
      begin
         @(posedge sys_clk);
         sec_ack <= 1'b1;
         @(posedge sys_clk);
         sec_ack <= 1'b0;
         @(posedge sys_clk);
      end
   endtask
endmodule // fip_seg_model
